// >>> src/dac_cal_path.sv
// Purpose: Gain and zero correction of a written code, saturated to the code span.
// Assumes: Purely combinational; the caller latches the result.
// Notes:   Result is left-justified in 16 bits so both widths share one slew engine.
`timescale 1ns/1ps
`default_nettype none
module dac_cal_path #(
	parameter int CODE_W = 16
) (
	input  wire logic [CODE_W-1:0] i_code,
	input  wire logic [15:0]       i_gain,
	input  wire logic [15:0]       i_zero,
	output logic      [15:0]       o_code
);
	localparam int SHIFT = 16 - CODE_W;
	localparam logic signed [18:0] CODE_MAX = 19'((1 << CODE_W) - 1);

	logic        [32:0]   prod;
	logic signed [18:0]   sum;
	logic        [CODE_W-1:0] sat;

	always_comb begin
		prod = 33'(i_code) * (33'(i_gain) + 33'(dac_ctrl_pkg::GAIN_OFFSET));
		sum = signed'({2'h0, prod[32:16]}) + 19'(signed'(i_zero));
		if (sum < 0) begin
			sat = '0;
		end else if (sum > CODE_MAX) begin
			sat = '1;
		end else begin
			sat = sum[CODE_W-1:0];
		end
		o_code = 16'(sat) << SHIFT;
	end
endmodule
`default_nettype wire

// >>> src/dac_calibration_slew_range_ctrl.sv
// Purpose: Calibrated, slew-limited output code with range decode behind AXI4-Lite.
// Assumes: Serial framing sits outside and flags the forcing pattern on this clock.
// Notes:   The clear pin is asynchronous and is synchronised before use.
`timescale 1ns/1ps
`default_nettype none
module dac_calibration_slew_range_ctrl #(
	parameter int unsigned CLK_HZ = dac_ctrl_pkg::CORE_CLK_HZ,
	parameter int          CODE_W = 16,
	parameter int          ADDR_W = 10
) (
	input  wire logic              i_core_clk,
	input  wire logic              i_reset_n,
	input  wire logic [ADDR_W-1:0] i_awaddr,
	input  wire logic              i_awvalid,
	output logic                   o_awready,
	input  wire logic [31:0]       i_wdata,
	input  wire logic [3:0]        i_wstrb,
	input  wire logic              i_wvalid,
	output logic                   o_wready,
	output logic [1:0]             o_bresp,
	output logic                   o_bvalid,
	input  wire logic              i_bready,
	input  wire logic [ADDR_W-1:0] i_araddr,
	input  wire logic              i_arvalid,
	output logic                   o_arready,
	output logic [31:0]            o_rdata,
	output logic [1:0]             o_rresp,
	output logic                   o_rvalid,
	input  wire logic              i_rready,
	input  wire logic              i_output_clear_input,
	input  wire logic              i_crc_pattern_det,
	output logic [CODE_W-1:0]      o_dac_code,
	output logic                   o_ramp_active_flag,
	output logic                   o_crc_mode,
	output logic                   o_voltage_output_en,
	output logic [1:0]             o_voltage_span,
	output logic                   o_voltage_overrange_enable,
	output logic                   o_current_output_en,
	output logic [1:0]             o_current_span
);
	localparam int SHIFT = 16 - CODE_W;

	// ****************************************************************
	// State
	// ****************************************************************
	logic [ADDR_W-1:0] awaddr_r;
	logic [31:0]       wdata_r;
	logic [3:0]        wstrb_r;
	logic              wr_fire;
	logic              wr_data, wr_ctrl, wr_gain, wr_zero, wr_cfg, wr_ok;
	logic [15:0]       gain_r, zero_r;
	logic [2:0]        range_r, range_nxt, step_sel_r;
	logic [3:0]        tick_sel_r;
	logic              clear_sel_r, slew_en_r, overrange_r;
	logic              dual_r, crc_en_r, crc_forced_r;
	logic [1:0]        ispan_r;
	logic [15:0]       ctrl_rd, ctrl_new, cfg_rd, cfg_new, code_rd, cal_out;
	logic [15:0]       data_new;
	logic              range_chg;
	logic [15:0]       target_r, pos_r, pos_nxt, tgt_eff, step;
	logic              ramp_r, tick;
	logic              clear_s1_r, clear_s2_r;

	function automatic logic [15:0] clear_code(input logic sel, input logic [2:0] rng);
		return (sel && !rng[2]) ? dac_ctrl_pkg::MID_CODE : dac_ctrl_pkg::ZERO_CODE;
	endfunction

	function automatic logic [15:0] step_of(input logic [2:0] sel);
		if (CODE_W == 16) begin
			return 16'h0001 << sel;
		end
		return {8'h00, dac_ctrl_pkg::STEP12[sel]};
	endfunction

	// ****************************************************************
	// AXI4-Lite slave
	// ****************************************************************
	assign wr_fire = !o_awready && !o_wready && !o_bvalid;

	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_awready <= 1'b1;
			awaddr_r  <= '0;
		end else if (i_awvalid && o_awready) begin
			o_awready <= 1'b0;
			awaddr_r  <= i_awaddr;
		end else if (o_bvalid && i_bready) begin
			o_awready <= 1'b1;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_wready <= 1'b1;
			wdata_r  <= '0;
			wstrb_r  <= '0;
		end else if (i_wvalid && o_wready) begin
			o_wready <= 1'b0;
			wdata_r  <= i_wdata;
			wstrb_r  <= i_wstrb;
		end else if (o_bvalid && i_bready) begin
			o_wready <= 1'b1;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_bvalid <= 1'b0;
			o_bresp  <= dac_ctrl_pkg::RESP_OKAY;
		end else if (wr_fire) begin
			o_bvalid <= 1'b1;
			o_bresp  <= wr_ok ? dac_ctrl_pkg::RESP_OKAY : dac_ctrl_pkg::RESP_SLVERR;
		end else if (i_bready) begin
			o_bvalid <= 1'b0;
		end
	end

	always_comb begin
		wr_data = 1'b0;
		wr_ctrl = 1'b0;
		wr_gain = 1'b0;
		wr_zero = 1'b0;
		wr_cfg  = 1'b0;
		wr_ok   = 1'b1;
		if (awaddr_r[ADDR_W-1:2] == dac_ctrl_pkg::IDX_DATA) begin
			wr_data = wr_fire;
		end else if (awaddr_r[ADDR_W-1:2] == dac_ctrl_pkg::IDX_CTRL) begin
			wr_ctrl = wr_fire;
		end else if (awaddr_r[ADDR_W-1:2] == dac_ctrl_pkg::IDX_GAIN) begin
			wr_gain = wr_fire;
		end else if (awaddr_r[ADDR_W-1:2] == dac_ctrl_pkg::IDX_ZERO) begin
			wr_zero = wr_fire;
		end else if (awaddr_r[ADDR_W-1:2] == dac_ctrl_pkg::IDX_CONFIG) begin
			wr_cfg = wr_fire;
		end else if (awaddr_r[ADDR_W-1:2] != dac_ctrl_pkg::IDX_STATUS) begin
			wr_ok = 1'b0;
		end
	end

	// Reads answer one cycle after the address is taken.
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_arready <= 1'b1;
			o_rvalid  <= 1'b0;
			o_rdata   <= '0;
			o_rresp   <= dac_ctrl_pkg::RESP_OKAY;
		end else if (i_arvalid && o_arready) begin
			o_arready <= 1'b0;
			o_rvalid  <= 1'b1;
			o_rresp   <= dac_ctrl_pkg::RESP_OKAY;
			o_rdata   <= '0;
			if (i_araddr[ADDR_W-1:2] == dac_ctrl_pkg::IDX_DATA) begin
				o_rdata <= 32'(code_rd);
			end else if (i_araddr[ADDR_W-1:2] == dac_ctrl_pkg::IDX_CTRL) begin
				o_rdata <= 32'(ctrl_rd);
			end else if (i_araddr[ADDR_W-1:2] == dac_ctrl_pkg::IDX_GAIN) begin
				o_rdata <= 32'(gain_r);
			end else if (i_araddr[ADDR_W-1:2] == dac_ctrl_pkg::IDX_ZERO) begin
				o_rdata <= 32'(zero_r);
			end else if (i_araddr[ADDR_W-1:2] == dac_ctrl_pkg::IDX_CONFIG) begin
				o_rdata <= 32'(cfg_rd);
			end else if (i_araddr[ADDR_W-1:2] == dac_ctrl_pkg::IDX_STATUS) begin
				o_rdata[dac_ctrl_pkg::STAT_RAMP_BIT]      <= ramp_r;
				o_rdata[dac_ctrl_pkg::STAT_CRC_FORCE_BIT] <= crc_forced_r;
			end else begin
				o_rresp <= dac_ctrl_pkg::RESP_SLVERR;
			end
		end else if (o_rvalid && i_rready) begin
			o_rvalid  <= 1'b0;
			o_arready <= 1'b1;
		end
	end

	// ****************************************************************
	// Register file
	// ****************************************************************
	always_comb begin
		ctrl_rd = '0;
		ctrl_rd[dac_ctrl_pkg::CTRL_RANGE_LSB +: 3]   = range_r;
		ctrl_rd[dac_ctrl_pkg::CTRL_CLEAR_SEL_BIT]    = clear_sel_r;
		ctrl_rd[dac_ctrl_pkg::CTRL_SLEW_BIT]         = slew_en_r;
		ctrl_rd[dac_ctrl_pkg::CTRL_STEP_LSB +: 3]    = step_sel_r;
		ctrl_rd[dac_ctrl_pkg::CTRL_TICK_LSB +: 4]    = tick_sel_r;
		ctrl_rd[dac_ctrl_pkg::CTRL_OVERRANGE_BIT]    = overrange_r;
		cfg_rd = '0;
		cfg_rd[dac_ctrl_pkg::CFG_DUAL_BIT]           = dual_r;
		cfg_rd[dac_ctrl_pkg::CFG_ISPAN_LSB +: 2]     = ispan_r;
		cfg_rd[dac_ctrl_pkg::CFG_CRC_BIT]            = crc_en_r;
		code_rd  = pos_r >> SHIFT;
		ctrl_new = dac_ctrl_pkg::merge16(ctrl_rd, wdata_r, wstrb_r);
		cfg_new  = dac_ctrl_pkg::merge16(cfg_rd, wdata_r, wstrb_r);
		data_new = dac_ctrl_pkg::merge16(code_rd, wdata_r, wstrb_r);
		range_nxt = ctrl_new[dac_ctrl_pkg::CTRL_RANGE_LSB +: 3];
		if (range_nxt == dac_ctrl_pkg::RANGE_FORBIDDEN) begin
			range_nxt = range_r;
		end
		range_chg = wr_ctrl && (range_nxt != range_r);
	end

	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			gain_r <= dac_ctrl_pkg::GAIN_RST;
			zero_r <= dac_ctrl_pkg::ZERO_RST;
		end else if (wr_gain) begin
			gain_r <= dac_ctrl_pkg::merge16(gain_r, wdata_r, wstrb_r);
		end else if (wr_zero) begin
			zero_r <= dac_ctrl_pkg::merge16(zero_r, wdata_r, wstrb_r);
		end
	end

	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			range_r     <= dac_ctrl_pkg::RANGE_RST;
			clear_sel_r <= 1'b0;
			slew_en_r   <= 1'b0;
			step_sel_r  <= '0;
			tick_sel_r  <= '0;
			overrange_r <= 1'b0;
		end else if (wr_ctrl) begin
			range_r     <= range_nxt;
			clear_sel_r <= ctrl_new[dac_ctrl_pkg::CTRL_CLEAR_SEL_BIT];
			slew_en_r   <= ctrl_new[dac_ctrl_pkg::CTRL_SLEW_BIT];
			step_sel_r  <= ctrl_new[dac_ctrl_pkg::CTRL_STEP_LSB +: 3];
			tick_sel_r  <= ctrl_new[dac_ctrl_pkg::CTRL_TICK_LSB +: 4];
			overrange_r <= ctrl_new[dac_ctrl_pkg::CTRL_OVERRANGE_BIT];
		end
	end

	// Once the pattern has forced checking on, software cannot change the enable.
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			dual_r       <= 1'b0;
			ispan_r      <= '0;
			crc_en_r     <= 1'b0;
			crc_forced_r <= 1'b0;
			o_crc_mode   <= 1'b0;
		end else begin
			if (wr_cfg) begin
				dual_r  <= cfg_new[dac_ctrl_pkg::CFG_DUAL_BIT];
				ispan_r <= cfg_new[dac_ctrl_pkg::CFG_ISPAN_LSB +: 2];
				if (!crc_forced_r) begin
					crc_en_r <= cfg_new[dac_ctrl_pkg::CFG_CRC_BIT];
				end
			end
			if (i_crc_pattern_det && !crc_en_r) begin
				crc_forced_r <= 1'b1;
			end
			o_crc_mode <= crc_en_r || crc_forced_r;
		end
	end

	// ****************************************************************
	// Calibration and target
	// ****************************************************************
	dac_cal_path #(
		.CODE_W (CODE_W)
	) u_cal (
		.i_code (data_new[CODE_W-1:0]),
		.i_gain (gain_r),
		.i_zero (zero_r),
		.o_code (cal_out)
	);

	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			target_r <= dac_ctrl_pkg::ZERO_CODE;
		end else if (range_chg) begin
			target_r <= clear_code(ctrl_new[dac_ctrl_pkg::CTRL_CLEAR_SEL_BIT], range_nxt);
		end else if (wr_data) begin
			target_r <= cal_out;
		end
	end

	// ****************************************************************
	// Slew engine
	// ****************************************************************
	// The clear pin is asynchronous to the core clock.
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			clear_s1_r <= 1'b0;
			clear_s2_r <= 1'b0;
		end else begin
			clear_s1_r <= i_output_clear_input;
			clear_s2_r <= clear_s1_r;
		end
	end

	ramp_tick_div #(
		.CLK_HZ (CLK_HZ)
	) u_div (
		.i_core_clk (i_core_clk),
		.i_reset_n  (i_reset_n),
		.i_sel      (tick_sel_r),
		.o_tick     (tick)
	);

	always_comb begin
		tgt_eff = clear_s2_r ? clear_code(clear_sel_r, range_r) : target_r;
		step    = step_of(step_sel_r);
		pos_nxt = pos_r;
		if (!slew_en_r) begin
			pos_nxt = tgt_eff;
		end else if (tick && pos_r < tgt_eff) begin
			pos_nxt = (tgt_eff - pos_r <= step) ? tgt_eff : pos_r + step;
		end else if (tick && pos_r > tgt_eff) begin
			pos_nxt = (pos_r - tgt_eff <= step) ? tgt_eff : pos_r - step;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			pos_r  <= dac_ctrl_pkg::ZERO_CODE;
			ramp_r <= 1'b0;
		end else begin
			pos_r  <= pos_nxt;
			ramp_r <= pos_nxt != tgt_eff;
		end
	end

	assign o_dac_code         = pos_r[15 -: CODE_W];
	assign o_ramp_active_flag = ramp_r;

	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_voltage_output_en        <= 1'b0;
			o_voltage_span             <= '0;
			o_voltage_overrange_enable <= 1'b0;
			o_current_output_en        <= 1'b0;
			o_current_span             <= '0;
		end else begin
			o_voltage_output_en        <= !range_r[2];
			o_voltage_span             <= range_r[1:0];
			o_voltage_overrange_enable <= overrange_r && !range_r[2];
			o_current_output_en        <= dual_r ? (ispan_r != 2'h0) : range_r[2];
			o_current_span             <= dual_r ? ispan_r : range_r[1:0];
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	sequence s_range_write;
		range_chg ##1 1'b1;
	endsequence

	a_crc_force_blocked: assert property (
		@(posedge i_core_clk) disable iff (!i_reset_n)
		crc_en_r && !crc_forced_r |=> !crc_forced_r)
		else $error("Pattern forced checking while enabled.");

	a_gain_reset_value: assert property (
		@(posedge i_core_clk) !i_reset_n |-> gain_r == dac_ctrl_pkg::GAIN_RST)
		else $error("Gain register not at reset value.");

	a_target_in_span: assert property (
		@(posedge i_core_clk) disable iff (!i_reset_n)
		wr_data |=> (target_r[SHIFT > 0 ? SHIFT - 1 : 0] == 1'b0 || SHIFT == 0))
		else $error("Target lies outside the code span.");

	a_cal_write_defer: assert property (
		@(posedge i_core_clk) disable iff (!i_reset_n)
		(wr_gain || wr_zero) && (!slew_en_r || !tick) && pos_r == tgt_eff
		|=> $stable(target_r) && $stable(pos_r))
		else $error("Calibration write moved the output.");

	a_slew_off_direct: assert property (
		@(posedge i_core_clk) disable iff (!i_reset_n)
		!slew_en_r |=> pos_r == $past(tgt_eff))
		else $error("Output not applied directly with slew off.");

	a_hold_between: assert property (
		@(posedge i_core_clk) disable iff (!i_reset_n)
		(slew_en_r && !tick) [*2] |-> ##1 $stable(pos_r))
		else $error("Output moved without an update tick.");

	a_ramp_settled: assert property (
		@(posedge i_core_clk) disable iff (!i_reset_n)
		!ramp_r && $stable(tgt_eff) |-> pos_r == tgt_eff)
		else $error("Ramp flag low while output off target.");

	a_range_forbidden: assert property (
		@(posedge i_core_clk) disable iff (!i_reset_n)
		wr_ctrl && ctrl_new[dac_ctrl_pkg::CTRL_RANGE_LSB +: 3] == dac_ctrl_pkg::RANGE_FORBIDDEN
		|=> $stable(range_r))
		else $error("Forbidden range code was stored.");

	a_range_clears: assert property (
		@(posedge i_core_clk) disable iff (!i_reset_n)
		s_range_write |-> target_r == clear_code(clear_sel_r, range_r))
		else $error("Range change did not clear the data.");

	a_no_overshoot: assert property (
		@(posedge i_core_clk) disable iff (!i_reset_n)
		slew_en_r && tick && pos_r < tgt_eff && $stable(tgt_eff)
		|=> pos_r <= $past(tgt_eff) && pos_r > $past(pos_r))
		else $error("Slew step overshot or stalled.");
endmodule
`default_nettype wire

// >>> src/dac_ctrl_pkg.sv
// Purpose: Shared constants for the calibrated, slew-limited output code path.
// Assumes: Registers sit on 32-bit AXI4-Lite words at byte address four times the index.
// Notes:   Frequencies are in hertz; divider counts are derived from them elsewhere.
package dac_ctrl_pkg;

	// ****************************************************************
	// Clock and register map
	// ****************************************************************
	localparam int unsigned CORE_CLK_HZ = 20_000_000;
	localparam logic [7:0]  IDX_DATA    = 8'h01;
	localparam logic [7:0]  IDX_CTRL    = 8'h55;
	localparam logic [7:0]  IDX_GAIN    = 8'h10;
	localparam logic [7:0]  IDX_ZERO    = 8'h11;
	localparam logic [7:0]  IDX_STATUS  = 8'h12;
	localparam logic [7:0]  IDX_CONFIG  = 8'h13;

	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int CTRL_RANGE_LSB     = 0;
	localparam int CTRL_CLEAR_SEL_BIT = 3;
	localparam int CTRL_SLEW_BIT      = 4;
	localparam int CTRL_STEP_LSB      = 5;
	localparam int CTRL_TICK_LSB      = 8;
	localparam int CTRL_OVERRANGE_BIT = 12;
	localparam int CFG_DUAL_BIT       = 0;
	localparam int CFG_ISPAN_LSB      = 1;
	localparam int CFG_CRC_BIT        = 3;
	localparam int STAT_CRC_FORCE_BIT = 0;
	localparam int STAT_RAMP_BIT      = 1;

	// ****************************************************************
	// Reset values and codes
	// ****************************************************************
	localparam logic [15:0] GAIN_RST        = 16'h0000;
	localparam logic [15:0] ZERO_RST        = 16'h0000;
	localparam logic [15:0] GAIN_OFFSET     = 16'h8000;
	localparam logic [2:0]  RANGE_RST       = 3'h0;
	localparam logic [2:0]  RANGE_FORBIDDEN = 3'h4;
	localparam logic [15:0] MID_CODE        = 16'h8000;
	localparam logic [15:0] ZERO_CODE       = 16'h0000;
	localparam logic [1:0]  RESP_OKAY       = 2'h0;
	localparam logic [1:0]  RESP_SLVERR     = 2'h2;

	// Update rates, one per tick select code.
	localparam int unsigned TICK_HZ [16] = '{258065, 200000, 153845, 131145,
		115940, 69565, 37560, 25805, 20150, 16030, 10295, 8280, 6900, 5530,
		4240, 3300};

	// Steps of the 12-bit variant in sixteenths of a code.
	localparam logic [7:0] STEP12 [8] = '{8'h01, 8'h02, 8'h02, 8'h08,
		8'h10, 8'h20, 8'h40, 8'h80};

	// Merges the enabled byte lanes of a write into a 16-bit register.
	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [31:0] wd, input logic [3:0] strb);
		logic [15:0] v;
		v = old;
		if (strb[0]) begin
			v[7:0] = wd[7:0];
		end
		if (strb[1]) begin
			v[15:8] = wd[15:8];
		end
		return v;
	endfunction

endpackage

// >>> src/ramp_tick_div.sv
// Purpose: Divides the core clock into the selected ramp update tick.
// Assumes: The select comes from logic on the same clock.
// Notes:   Counts truncate, so each rate is at or slightly above its nominal value.
`timescale 1ns/1ps
`default_nettype none
module ramp_tick_div #(
	parameter int unsigned CLK_HZ = dac_ctrl_pkg::CORE_CLK_HZ,
	parameter int          CNT_W  = 16
) (
	input  wire logic       i_core_clk,
	input  wire logic       i_reset_n,
	input  wire logic [3:0] i_sel,
	output logic            o_tick
);
	logic [CNT_W-1:0] lim_tab [16];
	logic [CNT_W-1:0] cnt_r;

	function automatic logic [CNT_W-1:0] last_count(input int unsigned hz);
		int unsigned n;
		n = CLK_HZ / hz;
		if (n < 1) begin
			n = 1;
		end
		return CNT_W'(n - 1);
	endfunction

	for (genvar g = 0; g < 16; g++) begin : g_lim
		assign lim_tab[g] = last_count(dac_ctrl_pkg::TICK_HZ[g]);
	end

	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			cnt_r  <= '0;
			o_tick <= 1'b0;
		end else if (cnt_r >= lim_tab[i_sel]) begin
			cnt_r  <= '0;
			o_tick <= 1'b1;
		end else begin
			cnt_r  <= cnt_r + 1'b1;
			o_tick <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// >>> testbench/host_axi_model.sv
// Purpose: Host model that writes and reads the block's registers.
// Assumes: One write or one read at a time, changed just after a rising edge.
// Notes:   Waits have no limit here; the bench timeout ends a hang.
`timescale 1ns/1ps
`default_nettype none
module host_axi_model (
	input  wire logic        i_core_clk,
	input  wire logic        i_awready,
	input  wire logic        i_wready,
	input  wire logic        i_bvalid,
	input  wire logic [1:0]  i_bresp,
	input  wire logic        i_arready,
	input  wire logic        i_rvalid,
	input  wire logic [31:0] i_rdata,
	input  wire logic [1:0]  i_rresp,
	output logic      [9:0]  o_awaddr,
	output logic             o_awvalid,
	output logic      [31:0] o_wdata,
	output logic      [3:0]  o_wstrb,
	output logic             o_wvalid,
	output logic             o_bready,
	output logic      [9:0]  o_araddr,
	output logic             o_arvalid,
	output logic             o_rready
);
	initial begin
		{o_awaddr, o_awvalid, o_wdata, o_wvalid, o_bready} = '0;
		{o_araddr, o_arvalid, o_rready} = '0;
		o_wstrb = 4'hf;
	end
	task automatic wr(input logic [9:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw;
		logic w;
		aw = 1'b1;
		w = 1'b1;
		@(posedge i_core_clk);
		o_awaddr <= a;
		o_wdata <= d;
		o_awvalid <= 1'b1;
		o_wvalid <= 1'b1;
		o_bready <= 1'b1;
		while (aw || w) begin
			@(posedge i_core_clk);
			if (aw && i_awready) begin
				aw = 1'b0;
				o_awvalid <= 1'b0;
			end
			if (w && i_wready) begin
				w = 1'b0;
				o_wvalid <= 1'b0;
			end
		end
		do @(posedge i_core_clk); while (!i_bvalid);
		r = i_bresp;
		o_bready <= 1'b0;
	endtask
	task automatic rd(input logic [9:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge i_core_clk);
		o_araddr <= a;
		o_arvalid <= 1'b1;
		o_rready <= 1'b1;
		do @(posedge i_core_clk); while (!i_arready);
		o_arvalid <= 1'b0;
		do @(posedge i_core_clk); while (!i_rvalid);
		d = i_rdata;
		r = i_rresp;
		o_rready <= 1'b0;
	endtask
endmodule
`default_nettype wire

// >>> testbench/tb_top.sv
// Purpose: Self-checking bench for the calibrated, slew-limited code path.
// Assumes: A slow divider clock setting keeps ramp ticks a few cycles apart.
// Notes:   Expected codes come from the bench's own calibration function.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	localparam logic [9:0] A_DAT = {dac_ctrl_pkg::IDX_DATA, 2'b00};
	localparam logic [9:0] A_CTL = {dac_ctrl_pkg::IDX_CTRL, 2'b00};
	localparam logic [9:0] A_GN  = {dac_ctrl_pkg::IDX_GAIN, 2'b00};
	localparam logic [9:0] A_ZR  = {dac_ctrl_pkg::IDX_ZERO, 2'b00};
	localparam logic [9:0] A_ST  = {dac_ctrl_pkg::IDX_STATUS, 2'b00};
	logic i_core_clk = 1'b0;
	logic i_reset_n = 1'b1;
	logic i_output_clear_input = 1'b0;
	logic i_crc_pattern_det = 1'b0;
	wire logic [9:0]  i_awaddr, i_araddr;
	wire logic [31:0] i_wdata, o_rdata;
	wire logic [3:0]  i_wstrb;
	wire logic [1:0]  o_bresp, o_rresp, o_voltage_span, o_current_span;
	wire logic [15:0] o_dac_code;
	wire logic i_awvalid, o_awready, i_wvalid, o_wready, o_bvalid, i_bready, i_arvalid;
	wire logic o_arready, o_rvalid, i_rready, o_ramp_active_flag, o_crc_mode;
	wire logic o_voltage_output_en, o_voltage_overrange_enable, o_current_output_en;
	wire logic [2:0] out_en = {o_voltage_output_en, o_voltage_overrange_enable, o_current_output_en};
	int err_total = 0;
	int checks_done = 0;
	int cyc = 0;
	int seed = 32'hcba1d10f;
	logic [31:0] rd;
	logic [15:0] c, g, z;
	logic [1:0]  rs;
	always #25 i_core_clk = ~i_core_clk;
	dac_calibration_slew_range_ctrl #(.CLK_HZ(1000000), .CODE_W(16), .ADDR_W(10)) u_dut (
		.i_core_clk, .i_reset_n, .i_awaddr, .i_awvalid, .o_awready, .i_wdata, .i_wstrb,
		.i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid,
		.o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready, .i_output_clear_input,
		.i_crc_pattern_det, .o_dac_code, .o_ramp_active_flag, .o_crc_mode,
		.o_voltage_output_en, .o_voltage_span, .o_voltage_overrange_enable,
		.o_current_output_en, .o_current_span);
	host_axi_model u_host (.i_core_clk, .i_awready(o_awready), .i_wready(o_wready),
		.i_bvalid(o_bvalid), .i_bresp(o_bresp), .i_arready(o_arready), .i_rvalid(o_rvalid),
		.i_rdata(o_rdata), .i_rresp(o_rresp), .o_awaddr(i_awaddr), .o_awvalid(i_awvalid),
		.o_wdata(i_wdata), .o_wstrb(i_wstrb), .o_wvalid(i_wvalid), .o_bready(i_bready),
		.o_araddr(i_araddr), .o_arvalid(i_arvalid), .o_rready(i_rready));
	// Floor division, then saturation to the 16-bit span.
	function automatic logic [15:0] cal(input logic [15:0] cd, gn, zr);
		logic [33:0] p;
		logic signed [33:0] v;
		p = {18'h0, cd} * ({18'h0, gn} + 34'h8000);
		v = $signed(p >> 16) + $signed({{18{zr[15]}}, zr});
		return (v < 0) ? 16'h0 : ((v > 34'sd65535) ? 16'hffff : v[15:0]);
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic settle;
		for (int i = 0; i < 5000 && o_ramp_active_flag !== 1'b0; i++) @(posedge i_core_clk);
		repeat (3) @(posedge i_core_clk);
	endtask
	task automatic give_verdict;
		$display("errors=%0d checks=%0d", err_total, checks_done);
		if (err_total == 0 && checks_done > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	always @(posedge i_core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			err_total++;
			give_verdict();
		end
	end
	initial begin
		i_reset_n <= 1'b0;
		repeat (16) @(posedge i_core_clk);
		i_reset_n <= 1'b1;
		u_host.rd(A_GN, rd, rs);
		chk(rd, 32'h0);
		u_host.rd(10'h3fc, rd, rs);
		chk({30'h0, rs}, {30'h0, dac_ctrl_pkg::RESP_SLVERR});
		// Corner gains and zeros first, then random ones.
		for (int k = 0; k < 12; k++) begin
			c = (k == 0) ? 16'hffff : 16'($random(seed));
			g = (k < 2) ? 16'hffff : ((k == 2) ? 16'h0 : 16'($random(seed)));
			z = (k == 1) ? 16'h8000 : 16'($random(seed));
			u_host.wr(A_GN, {16'h0, g}, rs);
			u_host.wr(A_ZR, {16'h0, z}, rs);
			u_host.wr(A_DAT, {16'h0, c}, rs);
			u_host.rd(A_DAT, rd, rs);
			chk(rd, {16'h0, cal(c, g, z)});
		end
		u_host.wr(A_GN, 32'h1234, rs);
		repeat (4) @(posedge i_core_clk);
		chk({16'h0, o_dac_code}, {16'h0, cal(c, g, z)});
		u_host.wr(A_GN, 32'h8000, rs);
		u_host.wr(A_ZR, 32'h0, rs);
		u_host.wr(A_DAT, 32'h0, rs);
		u_host.wr(A_CTL, 32'hf0, rs);
		u_host.wr(A_DAT, 32'hffff, rs);
		u_host.rd(A_ST, rd, rs);
		chk(rd & 32'h2, 32'h2);
		u_host.rd(A_DAT, rd, rs);
		chk({rd[31:16], rd[6:0], rd != 32'hffff}, 24'h1);
		settle();
		chk({o_dac_code, 15'h0, o_ramp_active_flag}, 32'hffff0000);
		i_output_clear_input <= 1'b1;
		repeat (8) @(posedge i_core_clk);
		chk({31'h0, o_ramp_active_flag}, 32'h1);
		settle();
		chk({16'h0, o_dac_code}, 32'h0);
		i_output_clear_input <= 1'b0;
		u_host.wr(A_CTL, 32'h1, rs);
		u_host.wr(A_DAT, 32'h4321, rs);
		u_host.wr(A_CTL, 32'h4, rs);
		u_host.rd(A_DAT, rd, rs);
		chk({14'h0, o_voltage_span, rd[15:0]}, 32'h14321);
		u_host.wr(A_CTL, 32'h1002, rs);
		u_host.rd(A_DAT, rd, rs);
		chk({14'h0, o_voltage_span, rd[15:0]}, 32'h20000);
		chk({29'h0, out_en}, 32'h6);
		u_host.wr(A_CTL, 32'h5, rs);
		u_host.rd(A_DAT, rd, rs);
		chk({11'h0, out_en, o_current_span, rd[15:0]}, 32'h50000);
		u_host.wr({dac_ctrl_pkg::IDX_CONFIG, 2'b00}, 32'h8, rs);
		i_crc_pattern_det <= 1'b1;
		@(posedge i_core_clk);
		i_crc_pattern_det <= 1'b0;
		u_host.rd(A_ST, rd, rs);
		chk({rd[0], o_crc_mode}, 2'b01);
		i_reset_n <= 1'b0;
		repeat (2) @(posedge i_core_clk);
		i_reset_n <= 1'b1;
		u_host.rd(A_GN, rd, rs);
		chk(rd, 32'h0);
		i_crc_pattern_det <= 1'b1;
		@(posedge i_core_clk);
		i_crc_pattern_det <= 1'b0;
		u_host.wr({dac_ctrl_pkg::IDX_CONFIG, 2'b00}, 32'h0, rs);
		u_host.rd(A_ST, rd, rs);
		chk({rd[0], o_crc_mode}, 2'b11);
		give_verdict();
	end
endmodule
`default_nettype wire
